// [design/nse_pkg.sv]
package nse_pkg;
   localparam logic [11:0] NSE_SP_ADDR     = 12'hf80;
   localparam logic [11:0] NSE_SP_HI_ADDR  = 12'hf81;
   localparam logic [11:0] NSE_PSW_ADDR    = 12'hfb0;
   localparam logic [11:0] NSE_PSW_HI_ADDR = 12'hfb1;
   localparam logic [3:0]  NSE_STACK_BANK  = 4'h0;
   localparam logic [2:0]  NSE_PAIR_LEN    = 3'h2;
   localparam logic [2:0]  NSE_FRAME_LEN   = 3'h6;
   localparam logic [1:0]  NSE_IS_TOP      = 2'h2;
   localparam logic [1:0]  NSE_IS_RESET    = 2'h0;
   localparam logic [2:0]  NSE_SKIP_RESET  = 3'h0;
   localparam logic [7:0]  NSE_SP_RESET    = 8'h00;
   localparam logic [13:0] NSE_PC_RESET    = 14'h0000;

   typedef enum logic [2:0] {
      NSE_CMD_PUSH_PAIR,
      NSE_CMD_POP_PAIR,
      NSE_CMD_CALL,
      NSE_CMD_RETURN,
      NSE_CMD_INT_ENTRY,
      NSE_CMD_INT_RETURN
   } nse_cmd_t;

   typedef struct packed {
      logic        we;
      logic        re;
      logic [11:0] addr;
      logic [3:0]  wdata;
   } nse_mem_t;
endpackage : nse_pkg

// [design/nse_stack_engine.sv]
`timescale 1ns/1ns
module nse_stack_engine (
   input  wire logic              ref_clk,
   input  wire logic              reset,
   input  wire logic [13:0]       reset_vector,
   input  wire logic              reset_mem_bank_enable,
   input  wire logic              reset_reg_bank_enable,
   input  wire logic              cmd_valid,
   input  wire nse_pkg::nse_cmd_t cmd,
   input  wire logic [7:0]        cmd_pair,
   input  wire logic [13:0]       cmd_target,
   output logic                   cmd_ready,
   output logic                   cmd_done,
   output logic [7:0]             pop_pair,
   input  wire logic              pc_adv_valid,
   input  wire logic [1:0]        pc_adv_len,
   input  wire logic              pc_load_valid,
   input  wire logic [13:0]       pc_load_value,
   output logic [13:0]            program_counter,
   input  wire logic              skip_we,
   input  wire logic [2:0]        skip_value,
   input  wire logic              reg_we,
   input  wire logic              reg_re,
   input  wire logic [11:0]       reg_addr,
   input  wire logic [7:0]        reg_wdata,
   output logic [7:0]             reg_rdata,
   output logic [7:0]             stack_pointer,
   output logic [7:0]             status_word,
   output nse_pkg::nse_mem_t      mem,
   input  wire logic [3:0]        mem_rdata
);
   typedef enum logic [1:0] {NSE_IDLE, NSE_PUSH, NSE_POP, NSE_DONE} nse_state_t;

   nse_state_t        state_q;
   nse_pkg::nse_cmd_t cmd_q;
   logic [7:0]        sp_q;
   logic [13:0]       pc_q;
   logic [13:0]       tgt_q;
   logic [7:0]        pair_q;
   logic [2:0]        idx_q;
   logic [2:0]        len_q;
   logic              rd_pend_q;
   logic [2:0]        rd_slot_q;
   logic [23:0]       frame_q;
   logic [23:0]       frame_d;
   logic [1:0]        is_q;
   logic              emb_q;
   logic              erb_q;
   logic              carry_q;
   logic [2:0]        skip_q;
   logic              last_nib;
   logic              accept;
   logic [3:0]        push_nib;
   logic              push_end;
   logic              pop_end;
   logic              sp_wr;

   assign cmd_ready       = (state_q == NSE_IDLE);
   assign accept          = cmd_valid && cmd_ready;
   assign last_nib        = (idx_q == len_q - 3'h1);
   assign push_end        = (state_q == NSE_PUSH) && last_nib;
   assign pop_end         = (state_q == NSE_DONE);
   assign sp_wr           = reg_we && (reg_addr == nse_pkg::NSE_SP_ADDR) && cmd_ready;
   assign program_counter = pc_q;
   assign stack_pointer   = sp_q;
   assign status_word     = {carry_q, skip_q, is_q, emb_q, erb_q};

   // Nibble k of a frame, written at pointer minus one minus k; order never varies
   always_comb begin
      push_nib = 4'h0;
      if (cmd_q == nse_pkg::NSE_CMD_PUSH_PAIR) begin
         push_nib = (idx_q == 3'h0) ? pair_q[7:4] : pair_q[3:0]; // Upper first
      end else begin
         case (idx_q)
            3'h0:    push_nib = pc_q[3:0];
            3'h1:    push_nib = pc_q[7:4];
            3'h2:    push_nib = pc_q[11:8];
            3'h3:    push_nib = {2'h0, pc_q[13:12]};
            3'h4:    push_nib = (cmd_q == nse_pkg::NSE_CMD_INT_ENTRY) ? {carry_q, skip_q} : 4'h0;
            default: push_nib = (cmd_q == nse_pkg::NSE_CMD_INT_ENTRY) ? {is_q, emb_q, erb_q}
                                                                      : {2'h0, emb_q, erb_q};
         endcase
      end
   end

   // Memory port; the top address nibble is pinned to bank zero whatever the bank flags say
   always_comb begin
      mem.we    = (state_q == NSE_PUSH);
      mem.re    = (state_q == NSE_POP);
      mem.wdata = push_nib;
      mem.addr  = {nse_pkg::NSE_STACK_BANK, sp_q + 8'(idx_q)};
      if (state_q == NSE_PUSH) begin
         mem.addr = {nse_pkg::NSE_STACK_BANK, sp_q - 8'h01 - 8'(idx_q)};
      end
   end

   // Read data lands one cycle after its strobe; newest nibble is read first
   always_comb begin
      frame_d = frame_q;
      if (rd_pend_q) begin
         frame_d[rd_slot_q*4 +: 4] = mem_rdata;
      end
   end

   // Sequencer of one push or pop burst
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_q   <= NSE_IDLE;
         cmd_q     <= nse_pkg::NSE_CMD_PUSH_PAIR;
         idx_q     <= 3'h0;
         len_q     <= nse_pkg::NSE_PAIR_LEN;
         tgt_q     <= nse_pkg::NSE_PC_RESET;
         pair_q    <= 8'h00;
         rd_pend_q <= 1'b0;
         rd_slot_q <= 3'h0;
         frame_q   <= 24'h000000;
      end else begin
         rd_pend_q <= (state_q == NSE_POP);
         rd_slot_q <= len_q - 3'h1 - idx_q; // Reverse of the write order
         frame_q   <= frame_d;
         case (state_q)
            NSE_IDLE: begin
               idx_q <= 3'h0;
               if (accept) begin
                  cmd_q  <= cmd;
                  tgt_q  <= cmd_target;
                  pair_q <= cmd_pair;
                  len_q  <= (cmd == nse_pkg::NSE_CMD_PUSH_PAIR || cmd == nse_pkg::NSE_CMD_POP_PAIR)
                            ? nse_pkg::NSE_PAIR_LEN : nse_pkg::NSE_FRAME_LEN;
                  state_q <= (cmd == nse_pkg::NSE_CMD_PUSH_PAIR || cmd == nse_pkg::NSE_CMD_CALL ||
                              cmd == nse_pkg::NSE_CMD_INT_ENTRY) ? NSE_PUSH : NSE_POP;
               end
            end
            NSE_PUSH: begin
               idx_q <= idx_q + 3'h1;
               if (last_nib) begin
                  state_q <= NSE_IDLE;
               end
            end
            NSE_POP: begin
               idx_q <= idx_q + 3'h1;
               if (last_nib) begin
                  state_q <= NSE_DONE;
               end
            end
            NSE_DONE: state_q <= NSE_IDLE;
            default:  state_q <= NSE_IDLE;
         endcase
      end
   end

   // Stack pointer: software byte writes, burst adjusts after the last nibble
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sp_q <= nse_pkg::NSE_SP_RESET; // Real part leaves this undefined; software must init
      end else if (push_end) begin
         sp_q <= sp_q - {5'h00, len_q}; // Two for a pair, six for a frame
      end else if (pop_end) begin
         sp_q <= sp_q + {5'h00, len_q};
      end else if (sp_wr) begin
         sp_q <= {reg_wdata[7:1], 1'b0}; // Bit zero forced low
      end
   end

   // Program counter: reset, interrupt vector, returns, jumps, then plain advance
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pc_q <= reset_vector;
      end else if (push_end && cmd_q != nse_pkg::NSE_CMD_PUSH_PAIR) begin
         pc_q <= tgt_q; // Vector or call target
      end else if (pop_end && cmd_q != nse_pkg::NSE_CMD_POP_PAIR) begin
         pc_q <= {frame_d[13:12], frame_d[11:0]};
      end else if (cmd_ready && pc_load_valid) begin
         pc_q <= pc_load_value; // Table reference and branches come this way
      end else if (cmd_ready && pc_adv_valid) begin
         pc_q <= pc_q + {12'h000, pc_adv_len};
      end
   end

   // Status word flags; software writes only when the engine is idle
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         is_q   <= nse_pkg::NSE_IS_RESET;
         skip_q <= nse_pkg::NSE_SKIP_RESET;
         emb_q  <= reset_mem_bank_enable;
         erb_q  <= reset_reg_bank_enable;
      end else if (push_end && cmd_q == nse_pkg::NSE_CMD_INT_ENTRY) begin
         is_q <= (is_q >= nse_pkg::NSE_IS_TOP) ? is_q : is_q + 2'h1; // Saved value goes out first
      end else if (pop_end && (cmd_q == nse_pkg::NSE_CMD_RETURN || cmd_q == nse_pkg::NSE_CMD_INT_RETURN)) begin
         emb_q <= frame_d[21];
         erb_q <= frame_d[20];
         if (cmd_q == nse_pkg::NSE_CMD_INT_RETURN) begin
            is_q   <= frame_d[23:22];
            skip_q <= frame_d[18:16];
         end
      end else if (cmd_ready && reg_we && reg_addr == nse_pkg::NSE_PSW_ADDR) begin
         {is_q, emb_q, erb_q} <= reg_wdata[3:0];
      end else if (skip_we) begin
         skip_q <= skip_value; // Skip flags are read-only to software
      end
   end

   // Carry has no reset value; a reset blocks software writes but not the restore that ends an interrupt return
   always_ff @(posedge ref_clk) begin
      if (pop_end && cmd_q == nse_pkg::NSE_CMD_INT_RETURN) begin
         carry_q <= frame_d[19];
      end else if (!reset && cmd_ready && reg_we && reg_addr == nse_pkg::NSE_PSW_ADDR) begin
         carry_q <= reg_wdata[7];
      end
   end

   // Registered answers: completion strobe, popped pair, byte reads
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cmd_done  <= 1'b0;
         pop_pair  <= 8'h00;
         reg_rdata <= 8'h00;
      end else begin
         cmd_done <= push_end || pop_end;
         if (pop_end && cmd_q == nse_pkg::NSE_CMD_POP_PAIR) begin
            pop_pair <= {frame_d[3:0], frame_d[7:4]}; // Lower read first, upper second
         end
         if (reg_re) begin
            case (reg_addr)
               nse_pkg::NSE_SP_ADDR:  reg_rdata <= sp_q;
               nse_pkg::NSE_PSW_ADDR: reg_rdata <= status_word;
               default:               reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   default clocking nse_cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   sp_bit_zero_a: assert property (sp_q[0] == 1'b0)
      else $error("stack pointer bit zero set");
   pair_push_dec_a: assert property (push_end && len_q == 3'h2 |=> sp_q == $past(sp_q) - 8'h02)
      else $error("pair push did not drop pointer by two");
   frame_push_dec_a: assert property (push_end && len_q == 3'h6 |=> sp_q == $past(sp_q) - 8'h06)
      else $error("frame push did not drop pointer by six");
   pop_inc_a: assert property (pop_end |=> sp_q == $past(sp_q) + {5'h00, $past(len_q)})
      else $error("pop did not raise pointer by its length");
   stack_bank_a: assert property (mem.we || mem.re |-> mem.addr[11:8] == 4'h0)
      else $error("stack access left bank zero");
   push_addr_a: assert property (mem.we |-> mem.addr[7:0] == sp_q - 8'h01 - {5'h00, idx_q})
      else $error("push address not below pointer");
   int_vector_a: assert property (push_end && cmd_q == nse_pkg::NSE_CMD_INT_ENTRY |=> pc_q == $past(tgt_q))
      else $error("interrupt entry did not load vector");
   level_step_a: assert property (push_end && cmd_q == nse_pkg::NSE_CMD_INT_ENTRY && is_q == 2'h0
                                  |=> is_q == 2'h1)
      else $error("level flags not advanced");
   pair_timing_a: assert property (accept && cmd == nse_pkg::NSE_CMD_PUSH_PAIR |=> mem.we [*2] ##1 cmd_ready)
      else $error("pair push not two writes");
   frame_pop_time_a: assert property (accept && cmd == nse_pkg::NSE_CMD_INT_RETURN |-> ##8 cmd_ready)
      else $error("interrupt return burst length wrong");

   call_seen_c:  cover property (push_end && cmd_q == nse_pkg::NSE_CMD_CALL);
   interrupt_return_seen_c:  cover property (pop_end && cmd_q == nse_pkg::NSE_CMD_INT_RETURN);
   pop_pair_c:   cover property (pop_end && cmd_q == nse_pkg::NSE_CMD_POP_PAIR);
endmodule : nse_stack_engine

// [test/nse_bank_memory.sv]
`timescale 1ns/1ns
module nse_bank_memory (
   input  wire logic              ref_clk,
   input  wire logic              reset,
   input  wire nse_pkg::nse_mem_t mem,
   output logic [3:0]             mem_rdata,
   output logic                   bank_fault
);
   logic [3:0] cells [0:255];

   // Bank 0 storage, only the low byte selects a cell
   always_ff @(posedge ref_clk) begin
      if (mem.we) begin
         cells[mem.addr[7:0]] <= mem.wdata;
      end
   end

   // Data follows re by one cycle; otherwise it toggles so stale data never looks valid
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         mem_rdata <= 4'h0;
      end else if (mem.re) begin
         mem_rdata <= cells[mem.addr[7:0]];
      end else begin
         mem_rdata <= ~mem_rdata;
      end
   end

   // Any stack access outside bank 0 is latched for the bench
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         bank_fault <= 1'b0;
      end else if ((mem.we || mem.re) && mem.addr[11:8] != 4'h0) begin
         bank_fault <= 1'b1;
      end
   end
endmodule : nse_bank_memory

// [test/nse_stack_engine_test.sv]
`timescale 1ns/1ns
module nse_stack_engine_test;
   logic              ref_clk = 1'b0;
   logic              reset, cmd_valid, cmd_ready, cmd_done, pc_adv_valid, pc_load_valid;
   logic              skip_we, reg_we, reg_re, bank_fault;
   nse_pkg::nse_cmd_t cmd;
   logic [7:0]        cmd_pair, pop_pair, reg_wdata, reg_rdata, stack_pointer, status_word, rd;
   logic [13:0]       cmd_target, pc_load_value, program_counter;
   logic [1:0]        pc_adv_len;
   logic [2:0]        skip_value;
   logic [11:0]       reg_addr;
   logic [3:0]        mem_rdata;
   nse_pkg::nse_mem_t mem;
   int                n_errors = 0;
   int                comparisons = 0;
   // Pushed pair, call frame, then interrupt frame, cells 0ffh down to 0f2h
   localparam logic [55:0] FRAME_IMAGE = 56'ha5_cba202_521052;

   nse_stack_engine u_nse_stack_engine (.ref_clk(ref_clk), .reset(reset), .reset_vector(14'h0100),
      .reset_mem_bank_enable(1'b1), .reset_reg_bank_enable(1'b0), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_pair(cmd_pair), .cmd_target(cmd_target), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
      .pop_pair(pop_pair), .pc_adv_valid(pc_adv_valid), .pc_adv_len(pc_adv_len),
      .pc_load_valid(pc_load_valid), .pc_load_value(pc_load_value), .program_counter(program_counter),
      .skip_we(skip_we), .skip_value(skip_value), .reg_we(reg_we), .reg_re(reg_re), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .stack_pointer(stack_pointer),
      .status_word(status_word), .mem(mem), .mem_rdata(mem_rdata));
   nse_bank_memory u_nse_bank_memory (.ref_clk(ref_clk), .reset(reset), .mem(mem), .mem_rdata(mem_rdata),
      .bank_fault(bank_fault));

   // 100 MHz core clock
   always #5 ref_clk = ~ref_clk;

   task automatic conclude;
      if (n_errors == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One command, held a single edge since the engine is idle between commands
   task automatic run_cmd(input nse_pkg::nse_cmd_t c, input logic [7:0] p, input logic [13:0] t);
      int i;
      @(negedge ref_clk);
      cmd_valid = 1'b1;
      cmd = c;
      cmd_pair = p;
      cmd_target = t;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      chk({15'h0, cmd_ready}, 16'h0000);
      for (i = 0; i < 20 && cmd_done !== 1'b1; i++) @(negedge ref_clk);
      if (i == 20) begin
         n_errors++;
         conclude();
      end
      chk({15'h0, cmd_ready}, 16'h0001);
      @(negedge ref_clk);
   endtask : run_cmd

   task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_we = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge ref_clk);
      reg_we = 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [11:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      reg_re = 1'b1;
      reg_addr = a;
      @(negedge ref_clk);
      reg_re = 1'b0;
      d = reg_rdata;
   endtask : reg_read

   // Main sequence: nested pair push, call and interrupt, then unwinding in reverse
   initial begin
      reset = 1'b1;
      {cmd_valid, pc_adv_valid, pc_load_valid, skip_we, reg_we, reg_re} = 6'h00;
      cmd = nse_pkg::NSE_CMD_PUSH_PAIR;
      {cmd_pair, reg_wdata, cmd_target, pc_load_value} = 44'h0;
      {pc_adv_len, skip_value, reg_addr} = 17'h0;
      repeat (12) @(negedge ref_clk);
      reset = 1'b0;
      chk({2'h0, program_counter}, 16'h0100);
      chk({12'h0, status_word[3:0]}, 16'h0002);
      reg_write(12'hf80, 8'h37);
      reg_read(12'hf80, rd);
      chk({8'h0, rd}, 16'h0036);
      reg_read(12'hf90, rd);
      chk({8'h0, rd}, 16'h0000);
      reg_write(12'hf80, 8'h00);
      reg_write(12'hfb0, 8'h02);
      @(negedge ref_clk);
      skip_we = 1'b1;
      skip_value = 3'h5;
      @(negedge ref_clk);
      skip_we = 1'b0;
      reg_read(12'hfb0, rd);
      chk({8'h0, rd}, 16'h0052);
      @(negedge ref_clk);
      pc_load_valid = 1'b1;
      pc_load_value = 14'h2abc;
      @(negedge ref_clk);
      pc_load_valid = 1'b0;
      run_cmd(nse_pkg::NSE_CMD_PUSH_PAIR, 8'ha5, 14'h0);
      chk({8'h0, stack_pointer}, 16'h00fe);
      run_cmd(nse_pkg::NSE_CMD_CALL, 8'h0, 14'h0123);
      chk({8'h0, stack_pointer}, 16'h00f8);
      @(negedge ref_clk);
      pc_adv_valid = 1'b1;
      pc_adv_len = 2'h2;
      @(negedge ref_clk);
      pc_adv_valid = 1'b0;
      chk({2'h0, program_counter}, 16'h0125);
      run_cmd(nse_pkg::NSE_CMD_INT_ENTRY, 8'h0, 14'h0040);
      chk({8'h0, stack_pointer}, 16'h00f2);
      chk({2'h0, program_counter}, 16'h0040);
      chk({8'h0, status_word}, 16'h0056);
      for (int i = 0; i < 14; i++) begin
         chk({12'h0, u_nse_bank_memory.cells[8'hff - i]}, {12'h0, FRAME_IMAGE[55 - 4 * i -: 4]});
      end
      chk({15'h0, bank_fault}, 16'h0000);
      // Disturb every saved flag so the return has something real to restore
      @(negedge ref_clk);
      skip_we = 1'b1;
      skip_value = 3'h2;
      @(negedge ref_clk);
      skip_we = 1'b0;
      reg_write(12'hfb0, 8'h89);
      chk({8'h0, status_word}, 16'h00a9);
      run_cmd(nse_pkg::NSE_CMD_INT_RETURN, 8'h0, 14'h0);
      chk({8'h0, stack_pointer}, 16'h00f8);
      chk({2'h0, program_counter}, 16'h0125);
      chk({8'h0, status_word}, 16'h0052);
      reg_write(12'hfb0, 8'h01);
      chk({8'h0, status_word}, 16'h0051);
      run_cmd(nse_pkg::NSE_CMD_RETURN, 8'h0, 14'h0);
      chk({8'h0, stack_pointer}, 16'h00fe);
      chk({2'h0, program_counter}, 16'h2abc);
      chk({8'h0, status_word}, 16'h0052);
      run_cmd(nse_pkg::NSE_CMD_POP_PAIR, 8'h0, 14'h0);
      chk({8'h0, pop_pair}, 16'h00a5);
      chk({8'h0, stack_pointer}, 16'h0000);
      conclude();
   end
endmodule : nse_stack_engine_test
